// ### pkg/daoc_defs.vh
// Constants for the dual converter output control block.
// Assumes inclusion by bare name from files under verilog/.
// Operation
// - Each channel samples on its own clock rise
// - Select high: A to bus A, B to bus B
// - Select low: buses swapped between channels
// - Awake, enabled: convert and drive bus
// - Awake, disabled: convert, outputs high impedance
// - Powered down, enabled: nap, high impedance
// - Powered down, disabled: sleep, high impedance
// - Each channel has own power and enable pins
// - One format setting serves both channels
// - Four format levels decode format and stabilizer
// - Over-range flag high on overflow or underflow
// - Twelve-bit parallel result, top bit is MSB
// - Result appears five sample clocks later
`ifndef DAOC_DEFS_VH
`define DAOC_DEFS_VH

// Result word and pipeline
`define DAOC_RES_W 12
`define DAOC_WORD_W 13
`define DAOC_PIPE_LAT 5
`define DAOC_FIFO_DEPTH 4
`define DAOC_FIFO_AW 2

// Four-level format pin codes
`define DAOC_FMT_GND 2'h0
`define DAOC_FMT_THIRD 2'h1
`define DAOC_FMT_TWO_THIRD 2'h2
`define DAOC_FMT_SUPPLY 2'h3

// One-hot power and output states
`define DAOC_ST_NORMAL 4'h1
`define DAOC_ST_HIZ 4'h2
`define DAOC_ST_NAP 4'h4
`define DAOC_ST_SLEEP 4'h8

// Reset values
`define DAOC_RES_RESET 12'h000
`define DAOC_FLAG_RESET 1'b0

`endif

// ### verilog/daoc_fifo.v
// Small synchronous FIFO between a converter pipeline and its output bus.
// Assumes one clock and an active-low reset already synchronised.
`timescale 1ns/10ps
`default_nettype none
module daoc_fifo #(
	parameter WIDTH = 13,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	input wire clk_in,
	input wire rst_n_in,
	input wire in_valid_in,
	output wire in_ready_out,
	input wire [WIDTH-1:0] in_data_in,
	output wire out_valid_out,
	input wire out_ready_in,
	output wire [WIDTH-1:0] out_data_out
);
	// Storage and pointers
	reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_reg;
	reg [AW-1:0] rd_ptr_reg;
	reg [AW:0] count_reg;
	wire push;
	wire pop;

	// Full stops the writer; empty hides stale words
	assign in_ready_out = (count_reg != DEPTH[AW:0]);
	assign out_valid_out = (count_reg != {(AW+1){1'b0}});
	assign push = in_valid_in & in_ready_out;
	assign pop = out_valid_out & out_ready_in;
	assign out_data_out = mem_reg[rd_ptr_reg];

	// Pointer and count update
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				// Wraps naturally when depth is a power of two
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end

	// Data array needs no reset
	always @(posedge clk_in) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data_in;
		end
	end
endmodule // daoc_fifo
`default_nettype wire

// ### verilog/daoc_top.v
// Output control of a dual pipelined sampling converter: per-channel
// sample pipelines, power states, code format, bus swap and bus drivers.
// Assumes all pins synchronous to core_clk_in and sample clocks slower
// than half the core clock so each rise is seen.
`timescale 1ns/10ps
`default_nettype none
`include "daoc_defs.vh"
module daoc_top #(
	parameter RES_W = `DAOC_RES_W,
	parameter PIPE_LAT = `DAOC_PIPE_LAT,
	parameter FIFO_DEPTH = `DAOC_FIFO_DEPTH,
	parameter FIFO_AW = `DAOC_FIFO_AW
) (
	input wire core_clk_in,
	input wire rst_b_in,
	input wire chan_a_sample_clock_in,
	input wire chan_b_sample_clock_in,
	input wire [RES_W-1:0] chan_a_raw_code_in,
	input wire chan_a_raw_over_in,
	input wire [RES_W-1:0] chan_b_raw_code_in,
	input wire chan_b_raw_over_in,
	input wire bus_swap_select_in,
	input wire chan_a_power_down_in,
	input wire chan_b_power_down_in,
	input wire chan_a_output_enable_n_in,
	input wire chan_b_output_enable_n_in,
	input wire [1:0] format_mode_in,
	output wire [RES_W-1:0] bus_a_result_out,
	output wire bus_a_result_oe_n_out,
	output wire bus_a_over_range_out,
	output wire bus_a_valid_out,
	input wire bus_a_ready_in,
	output wire [RES_W-1:0] bus_b_result_out,
	output wire bus_b_result_oe_n_out,
	output wire bus_b_over_range_out,
	output wire bus_b_valid_out,
	input wire bus_b_ready_in,
	output wire [3:0] chan_a_state_out,
	output wire [3:0] chan_b_state_out,
	output wire twos_complement_out,
	output wire stabilizer_on_out
);
	localparam WORD_W = RES_W + 1;
	// One-hot channel states
	localparam [3:0] ST_NORMAL = `DAOC_ST_NORMAL;
	localparam [3:0] ST_HIZ = `DAOC_ST_HIZ;
	localparam [3:0] ST_NAP = `DAOC_ST_NAP;
	localparam [3:0] ST_SLEEP = `DAOC_ST_SLEEP;

	// Reset release chain
	reg rst_meta_reg;
	reg rst_sync_reg;
	wire rst_n;

	// Shared format settings
	reg twos_reg;
	reg twos_next;
	reg stab_reg;
	reg stab_next;

	// Pin groups packed per channel, index 0 is A, 1 is B
	wire [1:0] sclk_pin;
	wire [1:0] pdown_pin;
	wire [1:0] oe_n_pin;
	wire [1:0] bus_ready;
	wire [2*RES_W-1:0] raw_code;
	wire [1:0] raw_over;
	// Per-channel and per-bus results of the generate loop
	wire [2*WORD_W-1:0] fifo_data;
	wire [1:0] fifo_valid;
	wire [1:0] fifo_ready;
	wire [1:0] bus_load_ok;
	wire [1:0] chan_awake;
	wire [7:0] chan_state;
	wire [2*RES_W-1:0] bus_res;
	wire [1:0] bus_over;
	wire [1:0] bus_valid;
	wire [1:0] bus_oe_n;
	// Swap flag: select low crosses the buses
	wire swap;

	// Release the asynchronous reset through two flops
	// Assertion stays asynchronous; only the release is timed to the clock
	always @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end
	assign rst_n = rst_sync_reg;

	// Decode the four-level format pin once for both channels
	always @* begin
		twos_next = 1'b0;
		stab_next = 1'b0;
		case (format_mode_in)
			`DAOC_FMT_GND: begin
				// Offset binary, stabilizer off
				twos_next = 1'b0;
				stab_next = 1'b0;
			end
			`DAOC_FMT_THIRD: begin
				twos_next = 1'b0;
				stab_next = 1'b1;
			end
			`DAOC_FMT_TWO_THIRD: begin
				twos_next = 1'b1;
				stab_next = 1'b1;
			end
			default: begin
				// Full supply level
				twos_next = 1'b1;
				stab_next = 1'b0;
			end
		endcase
	end

	// Format setting register
	// One register for both channels, so a change lands on both buses at once
	always @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			twos_reg <= 1'b0;
			stab_reg <= 1'b0;
		end else begin
			twos_reg <= twos_next;
			stab_reg <= stab_next;
		end
	end

	// Gather pins so the loop can index them
	assign sclk_pin = {chan_b_sample_clock_in, chan_a_sample_clock_in};
	assign pdown_pin = {chan_b_power_down_in, chan_a_power_down_in};
	assign oe_n_pin = {chan_b_output_enable_n_in, chan_a_output_enable_n_in};
	assign bus_ready = {bus_b_ready_in, bus_a_ready_in};
	assign raw_code = {chan_b_raw_code_in, chan_a_raw_code_in};
	assign raw_over = {chan_b_raw_over_in, chan_a_raw_over_in};
	// Select is read at each FIFO pop; words already in a bus register stay put
	// Changing it mid-stream may reorder words between the buses
	// Interleaving relies on the capture side tying select to both clocks
	assign swap = ~bus_swap_select_in;

	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : gen_ch
			// Channel side: clock edge, state, pipeline
			reg sclk_d_reg;
			reg [3:0] state_reg;
			reg [3:0] state_next;
			reg [WORD_W-1:0] pipe_reg [0:PIPE_LAT-1];
			reg [PIPE_LAT-1:0] pipe_vld_reg;
			wire sclk_rise;
			wire advance;
			// Bus side: output registers for bus g
			reg [RES_W-1:0] res_reg;
			reg over_reg;
			reg vld_reg;
			reg oe_n_reg;
			wire [WORD_W-1:0] src_word;
			wire src_valid;
			wire src_awake_en;
			wire load;
			integer k;

			// Delay flop resets low like an idle pin, so no false rise after reset
			// Rising edge of this channel's own sample clock
			assign sclk_rise = sclk_pin[g] & ~sclk_d_reg;

			// Power and output state from this channel's pin pair
			always @* begin
				state_next = ST_NORMAL;
				case ({pdown_pin[g], oe_n_pin[g]})
					2'b00: state_next = ST_NORMAL;
					2'b01: state_next = ST_HIZ;
					2'b10: state_next = ST_NAP;
					2'b11: state_next = ST_SLEEP;
					default: state_next = ST_SLEEP;
				endcase
			end

			// Hiz keeps converting so the pipeline stays primed for enable
			// Limitation: words already queued still drain while the channel naps
			// Converting states keep the pipeline running
			assign chan_awake[g] = state_reg[0] | state_reg[1];
			// Full FIFO holds the pipeline; samples at that edge are lost
			assign advance = sclk_rise & chan_awake[g] & fifo_ready[g];

			// Edge detector and state register
			always @(posedge core_clk_in or negedge rst_n) begin
				if (!rst_n) begin
					sclk_d_reg <= 1'b0;
					state_reg <= ST_SLEEP;
				end else begin
					sclk_d_reg <= sclk_pin[g];
					case (state_next)
						ST_NORMAL: state_reg <= ST_NORMAL;
						ST_HIZ: state_reg <= ST_HIZ;
						ST_NAP: state_reg <= ST_NAP;
						ST_SLEEP: state_reg <= ST_SLEEP;
						default: state_reg <= ST_SLEEP;
					endcase
				end
			end

			// Five-stage pipeline of code plus over-range flag
			always @(posedge core_clk_in or negedge rst_n) begin
				if (!rst_n) begin
					pipe_vld_reg <= {PIPE_LAT{1'b0}};
				end else if (!chan_awake[g]) begin
					// Nap or sleep clears its valid bits; wake refills over full latency
					pipe_vld_reg <= {PIPE_LAT{1'b0}};
				end else if (advance) begin
					pipe_vld_reg <= {pipe_vld_reg[PIPE_LAT-2:0], 1'b1};
				end
			end

			// Pipeline data needs no reset, only valid bits do
			always @(posedge core_clk_in) begin
				if (advance) begin
					pipe_reg[0] <= {raw_over[g], raw_code[g*RES_W +: RES_W]};
					for (k = 1; k < PIPE_LAT; k = k + 1) begin
						pipe_reg[k] <= pipe_reg[k-1];
					end
				end
			end

			// Word leaves the last stage on the fifth edge after capture
			// Four words absorb a short capture stall without losing samples
			daoc_fifo #(
				.WIDTH(WORD_W),
				.DEPTH(FIFO_DEPTH),
				.AW(FIFO_AW)
			) u_fifo (
				.clk_in(core_clk_in),
				.rst_n_in(rst_n),
				.in_valid_in(advance & pipe_vld_reg[PIPE_LAT-1]),
				.in_ready_out(fifo_ready[g]),
				.in_data_in(pipe_reg[PIPE_LAT-1]),
				.out_valid_out(fifo_valid[g]),
				.out_ready_in(bus_load_ok[g ^ swap]),
				.out_data_out(fifo_data[g*WORD_W +: WORD_W])
			);

			// Bus g takes channel g, or the other one when swapped
			assign src_word = fifo_data[(g ^ swap)*WORD_W +: WORD_W];
			assign src_valid = fifo_valid[g ^ swap];
			assign src_awake_en = chan_state[(g ^ swap)*4];
			// Free when empty or when the standing word is taken this edge
			assign bus_load_ok[g] = ~vld_reg | bus_ready[g];
			assign load = src_valid & bus_load_ok[g];

			// Bus output registers with format applied at the last step
			always @(posedge core_clk_in or negedge rst_n) begin
				if (!rst_n) begin
					res_reg <= `DAOC_RES_RESET;
					over_reg <= `DAOC_FLAG_RESET;
					vld_reg <= 1'b0;
					oe_n_reg <= 1'b1;
				end else begin
					// Only a normal source drives; others float the bus
					oe_n_reg <= ~src_awake_en;
					if (load) begin
						// MSB flips for two's complement; flag unchanged
						res_reg <= {src_word[RES_W-1] ^ twos_reg,
							src_word[RES_W-2:0]};
						over_reg <= src_word[RES_W];
						vld_reg <= 1'b1;
					end else if (bus_ready[g]) begin
						vld_reg <= 1'b0;
					end
				end
			end

			assign chan_state[g*4 +: 4] = state_reg;
			assign bus_res[g*RES_W +: RES_W] = res_reg;
			assign bus_over[g] = over_reg;
			assign bus_valid[g] = vld_reg;
			assign bus_oe_n[g] = oe_n_reg;
		end
	endgenerate

	// Each bus drives its own pins; swapping is done inside the loop
	// Bus A pins
	assign bus_a_result_out = bus_res[RES_W-1:0];
	assign bus_a_over_range_out = bus_over[0];
	assign bus_a_valid_out = bus_valid[0];
	assign bus_a_result_oe_n_out = bus_oe_n[0];
	// Bus B pins
	assign bus_b_result_out = bus_res[2*RES_W-1:RES_W];
	assign bus_b_over_range_out = bus_over[1];
	assign bus_b_valid_out = bus_valid[1];
	assign bus_b_result_oe_n_out = bus_oe_n[1];
	// Status pins
	// Lets the capture side tell nap and sleep apart from a plain disable
	assign chan_a_state_out = chan_state[3:0];
	assign chan_b_state_out = chan_state[7:4];
	assign twos_complement_out = twos_reg;
	assign stabilizer_on_out = stab_reg;
endmodule // daoc_top
`default_nettype wire

// ### sim/daoc_top_sva.sv
// Checker for the dual converter output control top.
// Assumes binding onto daoc_top; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module daoc_top_sva #(
	parameter RES_W = 12
) (
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	input wire logic bus_swap_select_in,
	input wire logic chan_a_power_down_in,
	input wire logic chan_a_output_enable_n_in,
	input wire logic chan_b_power_down_in,
	input wire logic chan_b_output_enable_n_in,
	input wire logic [1:0] format_mode_in,
	input wire logic [RES_W-1:0] bus_a_result_out,
	input wire logic bus_a_result_oe_n_out,
	input wire logic bus_a_over_range_out,
	input wire logic bus_a_valid_out,
	input wire logic bus_a_ready_in,
	input wire logic [3:0] chan_a_state_out,
	input wire logic [3:0] chan_b_state_out,
	input wire logic twos_complement_out,
	input wire logic stabilizer_on_out
);
	// Edges since reset release; pins load on the third, so wait it out
	logic [1:0] up_cnt;
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			up_cnt <= 2'h0;
		end else if (up_cnt != 2'h3) begin
			up_cnt <= up_cnt + 2'h1;
		end
	end
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (up_cnt != 2'h3);
	norm_state_a: assert property (
		!chan_a_power_down_in && !chan_a_output_enable_n_in |=> chan_a_state_out == 4'h1)
		else $error("channel A not normal");
	hiz_state_a: assert property (
		!chan_a_power_down_in && chan_a_output_enable_n_in |=> chan_a_state_out == 4'h2)
		else $error("channel A not high impedance");
	nap_state_a: assert property (
		chan_a_power_down_in && !chan_a_output_enable_n_in |=> chan_a_state_out == 4'h4)
		else $error("channel A not napping");
	sleep_state_a: assert property (
		chan_a_power_down_in && chan_a_output_enable_n_in |=> chan_a_state_out == 4'h8)
		else $error("channel A not asleep");
	own_pins_b_a: assert property (
		chan_b_power_down_in && chan_b_output_enable_n_in |=> chan_b_state_out == 4'h8)
		else $error("channel B not asleep");
	format_decode_a: assert property (
		1'b1 |=> twos_complement_out == $past(format_mode_in[1])
		&& stabilizer_on_out == ^$past(format_mode_in))
		else $error("format decode wrong");
	bus_drive_a: assert property (
		!bus_a_result_oe_n_out && $stable(bus_swap_select_in) |->
		($past(bus_swap_select_in) ? $past(chan_a_state_out) : $past(chan_b_state_out)) == 4'h1)
		else $error("bus A driven by idle channel");
	word_holds_a: assert property (
		bus_a_valid_out && !bus_a_ready_in |=> bus_a_valid_out
		&& $stable(bus_a_result_out) && $stable(bus_a_over_range_out))
		else $error("bus A word dropped before taken");
endmodule // daoc_top_sva
bind daoc_top daoc_top_sva #(.RES_W(RES_W)) u_sva (.core_clk_in, .rst_b_in, .bus_swap_select_in,
	.chan_a_power_down_in, .chan_a_output_enable_n_in, .chan_b_power_down_in,
	.chan_b_output_enable_n_in, .format_mode_in, .bus_a_result_out, .bus_a_result_oe_n_out,
	.bus_a_over_range_out, .bus_a_valid_out, .bus_a_ready_in, .chan_a_state_out,
	.chan_b_state_out, .twos_complement_out, .stabilizer_on_out);
`default_nettype wire

// ### sim/daoc_capture_model.sv
// Capture side taking words off one result bus.
// Assumes the bench stalls it to back the converter up.
`timescale 1ns/10ps
`default_nettype none
module daoc_capture_model (
	input wire logic clk_in,
	input wire logic valid_in,
	input wire logic stall_in,
	output logic ready_out
);
	// Takes a word on any edge unless stalled; valid is not needed
	assign ready_out = !stall_in;
endmodule // daoc_capture_model
`default_nettype wire

// ### sim/daoc_top_tb.sv
// Bench for the dual converter output control top.
// Assumes one core clock; both sample clocks share one bench line.
`timescale 1ns/10ps
`default_nettype none
module daoc_top_tb;
	logic clk, rst_b, sclk, ov_a, ov_b, sel, pd_a, pd_b, oe_a, oe_b, stall;
	logic [11:0] code_a, code_b, res_a, res_b;
	logic [1:0] fmt;
	logic [3:0] st_a, st_b;
	wire logic va, vb, ra, rb, o_a, o_b, oen_a, oen_b, twos, stab;
	logic [12:0] qa[$], qb[$]; // Expected words per bus
	int n_fail, comparisons;
	daoc_top u_dut (.core_clk_in(clk), .rst_b_in(rst_b),
		.chan_a_sample_clock_in(sclk), .chan_b_sample_clock_in(sclk),
		.chan_a_raw_code_in(code_a), .chan_a_raw_over_in(ov_a),
		.chan_b_raw_code_in(code_b), .chan_b_raw_over_in(ov_b), .bus_swap_select_in(sel),
		.chan_a_power_down_in(pd_a), .chan_b_power_down_in(pd_b),
		.chan_a_output_enable_n_in(oe_a), .chan_b_output_enable_n_in(oe_b),
		.format_mode_in(fmt), .bus_a_result_out(res_a), .bus_a_result_oe_n_out(oen_a),
		.bus_a_over_range_out(o_a), .bus_a_valid_out(va), .bus_a_ready_in(ra),
		.bus_b_result_out(res_b), .bus_b_result_oe_n_out(oen_b), .bus_b_over_range_out(o_b),
		.bus_b_valid_out(vb), .bus_b_ready_in(rb), .chan_a_state_out(st_a),
		.chan_b_state_out(st_b), .twos_complement_out(twos), .stabilizer_on_out(stab));
	daoc_capture_model u_cap_a (.clk_in(clk), .valid_in(va), .stall_in(stall), .ready_out(ra));
	daoc_capture_model u_cap_b (.clk_in(clk), .valid_in(vb), .stall_in(stall), .ready_out(rb));
	// 20 MHz core clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task check(input logic [12:0] got, input logic [12:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task report_and_stop;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Every taken word must be the oldest expected one on that bus
	always @(posedge clk) begin
		if (rst_b && va && ra) check({o_a, res_a}, qa.size() ? qa.pop_front() : 13'h1fff);
		if (rst_b && vb && rb) check({o_b, res_b}, qb.size() ? qb.pop_front() : 13'h1fff);
	end
	// All four states on A while B stays normal, then B asleep on its own
	task modes;
		for (int k = 0; k < 4; k++) begin
			pd_a = k[1];
			oe_a = k[0];
			repeat (3) @(negedge clk);
			check({9'h0, st_a}, 13'h1 << k);
			check({12'h0, oen_a}, {12'h0, k != 0});
			check({9'h0, st_b}, 13'h1);
			check({12'h0, oen_b}, 13'h0);
		end
		pd_a = 1'b0;
		oe_a = 1'b0;
		pd_b = 1'b1;
		oe_b = 1'b1;
		repeat (3) @(negedge clk);
		check({9'h0, st_b}, 13'h8);
		check({12'h0, oen_b}, 13'h1);
		check({9'h0, st_a}, 13'h1);
		pd_b = 1'b0;
		oe_b = 1'b0;
	endtask
	// n rises; only the first keep words of n-5 survive a stalled bus
	task run(input logic s, input logic [1:0] f, input int n, input int keep, input logic st);
		logic [12:0] wa, wb;
		sel = s;
		fmt = f;
		stall = st;
		repeat (2) @(negedge clk);
		check({11'h0, twos, stab}, {11'h0, f[1], ^f});
		check({11'h0, oen_a, oen_b}, 13'h0);
		for (int i = 0; i < n; i++) begin
			code_a = 12'h0a5 + 12'(i * 37);
			code_b = 12'hf00 - 12'(i * 5);
			ov_a = i[0];
			ov_b = i[1];
			wa = {ov_a, code_a ^ {f[1], 11'h0}};
			wb = {ov_b, code_b ^ {f[1], 11'h0}};
			if (i < n - 5 && i < keep) begin
				if (s) begin
					qa.push_back(wa);
					qb.push_back(wb);
				end else begin
					qb.push_back(wa);
					qa.push_back(wb);
				end
			end
			sclk = 1'b1;
			repeat (2) @(negedge clk);
			sclk = 1'b0;
			repeat (2) @(negedge clk);
		end
		stall = 1'b0;
		repeat (20) @(negedge clk);
		check(13'(qa.size() + qb.size()), 13'h0);
		// Power down empties both pipelines before the next scenario
		pd_a = 1'b1;
		pd_b = 1'b1;
		repeat (3) @(negedge clk);
		pd_a = 1'b0;
		pd_b = 1'b0;
		repeat (3) @(negedge clk);
	endtask
	// Cut a hang short well past the expected run length
	initial begin
		#150000;
		n_fail++;
		report_and_stop;
	end
	initial begin
		{rst_b, sclk, ov_a, ov_b, pd_a, pd_b, oe_a, oe_b, stall, fmt} = '0;
		sel = 1'b1;
		code_a = 12'h0;
		code_b = 12'h0;
		repeat (16) @(negedge clk);
		rst_b = 1'b1;
		repeat (4) @(negedge clk);
		modes;
		for (int f = 0; f < 4; f++) run(f[0], 2'(f), 9, 9, 1'b0);
		run(1'b1, 2'h2, 13, 5, 1'b1);
		report_and_stop;
	end
endmodule // daoc_top_tb
`default_nettype wire
